// ### hdl/status_word_ctrl.sv
// status word, condition code and privilege control with apb access
// Behaviour
// - bit 0 of the status word is the privilege flag; set allows privileged ops
// - bits 1 to 4 hold the four-bit condition code
// - bit 5 selects nonextended (0) or extended (1) addressing
// - bit 6 marks last instruction: 0 left or full word, 1 right half
// - bits 13 to 29 hold next word address; bits 7 to 12 stay zero
// - bit 30 marks next instruction position: 0 left, 1 right half
// - branch-and-link writes its effective address into bits 13 to 30
// - indirect branch also copies bits 1 to 4 of the indirect word
// - first condition bit set when an arithmetic exception occurred
// - condition bits two, three, four flag greater, less, equal zero
// - privileged instruction while unprivileged traps instead of executing
// - interrupt, mapping, io, halt and control-store instructions are privileged
// - interrupts, traps and calls load new status with privilege set
// - every trap and interrupt vectors into protected memory
// - only reset-interrupt branch or doubleword load can drop privilege
// - system reset clears registers, drops protection, sets privilege
// - unprivileged operation enforces protection, forbids privileged operations
// - base mode uses 19-bit address directly within first 512K bytes
// - extended mode operands reach anywhere in 16 megabytes
// - mapped modes allowed only in doubleword status mode
// - mapped-extended fetches only from primary space, operands from either
// - single-word mode supports only io classes 0 to 3 and E
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module status_word_ctrl (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_instr_valid,
   input wire status_word_pkg::instr_kind_t i_instr_kind,
   input wire logic i_cc_defined,
   input wire logic i_arith_exc,
   input wire logic [31:0] i_result,
   input wire logic i_last_right,
   input wire logic [17:0] i_next_loc,
   input wire logic [17:0] i_branch_ea,
   input wire logic i_indirect,
   input wire logic [31:0] i_indirect_word,
   input wire logic [31:0] i_new_status,
   input wire logic [3:0] i_io_class,
   input wire logic i_event_req,
   input wire status_word_pkg::cause_t i_event_cause,
   input wire logic [31:0] i_event_status,
   input wire logic i_acc_valid,
   input wire logic i_acc_fetch,
   input wire logic i_acc_ext_space,
   input wire logic [status_word_pkg::ADDR_W-1:0] i_acc_addr,
   output logic [31:0] o_status_word,
   output logic o_privileged,
   output logic o_mem_protect_en,
   output logic o_doubleword_mode,
   output logic o_gpr_clear,
   output logic o_vector_valid,
   output logic [status_word_pkg::ADDR_W-1:0] o_vector_addr,
   output status_word_pkg::cause_t o_vector_cause,
   output logic o_instr_blocked,
   output logic o_addr_fault
);
   import status_word_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic reset_seen;
      logic [31:0] status;
      logic doubleword;
      logic mapped;
      cause_t last_cause;
      logic gpr_clear;
      logic vector_valid;
      logic [ADDR_W-1:0] vector_addr;
      cause_t vector_cause;
      logic blocked;
      logic [31:0] prdata;
   } state_t;

   state_t state_reg;
   state_t state_next;
   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic addr_fault;
   logic access_phase;
   logic setup_phase;
   logic addr_hit;
   logic is_priv_kind;
   logic io_class_ok;
   logic trap_now;
   cause_t trap_cause;
   logic [31:0] trap_status;

   ////////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////////
   // addressing mode limits
   addr_mode_check u_addr_check (
      .i_extended(state_reg.status[EXT_BIT]),
      .i_mapped(state_reg.mapped),
      .i_doubleword(state_reg.doubleword),
      .i_fetch(i_acc_fetch),
      .i_ext_space(i_acc_ext_space),
      .i_addr(i_acc_addr),
      .o_fault(addr_fault)
   );

   assign o_addr_fault = i_acc_valid && addr_fault;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   assign setup_phase = i_psel && !i_penable;
   assign access_phase = i_psel && i_penable;
   assign addr_hit = (i_paddr == STATUS_WORD_OFF) || (i_paddr == CONTROL_OFF) || (i_paddr == TRAP_INFO_OFF);
   assign o_pready = access_phase;
   assign o_pslverr = access_phase && !addr_hit;

   ////////////////////////////////////////////////////////////////////////////
   // instruction classification
   always_comb begin
      case (i_instr_kind)
         kind_privileged, kind_io, kind_branch_reset_int, kind_load_doubleword: begin
            is_priv_kind = 1'b1;
         end
         default: begin
            is_priv_kind = 1'b0;
         end
      endcase
      io_class_ok = state_reg.doubleword || (i_io_class <= IO_CLASS_MAX_LOW) || (i_io_class == IO_CLASS_E);
   end

   // trap or event selection, external request first
   always_comb begin
      trap_now = 1'b0;
      trap_cause = cause_none;
      if (i_event_req) begin
         trap_now = 1'b1;
         trap_cause = i_event_cause;
      end else if (i_instr_valid) begin
         if (is_priv_kind && !state_reg.status[PRIV_BIT]) begin
            trap_now = 1'b1;
            trap_cause = cause_priv_violation;
         end else if (i_instr_kind == kind_io && !io_class_ok) begin
            trap_now = 1'b1;
            trap_cause = cause_undefined;
         end else if (i_instr_kind == kind_monitor_call) begin
            trap_now = 1'b1;
            trap_cause = cause_monitor_call;
         end else if (i_instr_kind == kind_supervisor_call) begin
            trap_now = 1'b1;
            trap_cause = cause_supervisor_call;
         end
      end
      trap_status = i_event_status & STATUS_WRITE_MASK;
      trap_status[PRIV_BIT] = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_next = state_reg;
      state_next.gpr_clear = 1'b0;
      state_next.vector_valid = 1'b0;
      state_next.blocked = 1'b0;

      // first cycle after reset release clears the register file
      if (!state_reg.reset_seen) begin
         state_next.reset_seen = 1'b1;
         state_next.gpr_clear = 1'b1;
      end

      // apb read data captured in the setup cycle
      if (setup_phase && !i_pwrite) begin
         case (i_paddr)
            STATUS_WORD_OFF: begin
               state_next.prdata = state_reg.status;
            end
            CONTROL_OFF: begin
               state_next.prdata = {30'h0, state_reg.mapped, state_reg.doubleword};
            end
            TRAP_INFO_OFF: begin
               state_next.prdata = {28'h0, state_reg.last_cause};
            end
            default: begin
               state_next.prdata = 32'h0;
            end
         endcase
      end

      // apb writes; privilege can only be kept or raised here
      if (access_phase && i_pwrite) begin
         case (i_paddr)
            STATUS_WORD_OFF: begin
               state_next.status = i_pwdata & STATUS_WRITE_MASK;
               state_next.status[PRIV_BIT] = i_pwdata[PRIV_BIT] | state_reg.status[PRIV_BIT];
            end
            CONTROL_OFF: begin
               state_next.doubleword = i_pwdata[CTL_DOUBLEWORD_BIT];
               state_next.mapped = i_pwdata[CTL_MAPPED_BIT];
            end
            default: begin
               state_next.doubleword = state_reg.doubleword;
            end
         endcase
      end

      // hardware updates take precedence over a same-cycle apb write
      if (trap_now) begin
         state_next.status = trap_status;
         state_next.last_cause = trap_cause;
         state_next.vector_valid = 1'b1;
         state_next.vector_cause = trap_cause;
         state_next.vector_addr = VECTOR_BASE + {{(ADDR_W - 6){1'b0}}, trap_cause, 2'b00};
         state_next.blocked = (trap_cause == cause_priv_violation) || (trap_cause == cause_undefined);
      end else if (i_instr_valid) begin
         case (i_instr_kind)
            kind_branch_link: begin
               state_next.status[NEXT_POS_BIT:PC_LO] = i_branch_ea;
               state_next.status[LAST_POS_BIT] = i_last_right;
               if (i_indirect) begin
                  state_next.status[CC_HI:CC_LO] = i_indirect_word[CC_HI:CC_LO];
               end
            end
            kind_branch_reset_int, kind_load_doubleword: begin
               state_next.status = i_new_status & STATUS_WRITE_MASK;
            end
            default: begin
               state_next.status[NEXT_POS_BIT:PC_LO] = i_next_loc;
               state_next.status[LAST_POS_BIT] = i_last_right;
               if (i_cc_defined) begin
                  state_next.status[CC_LO] = i_arith_exc;
                  state_next.status[CC_LO + 1] = !i_result[31] && (|i_result);
                  state_next.status[CC_LO + 2] = i_result[31];
                  state_next.status[CC_HI] = ~|i_result;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers; reset leaves the machine privileged and unprotected
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg.reset_seen <= 1'b0;
         state_reg.status <= STATUS_RESET;
         state_reg.doubleword <= CONTROL_RESET[CTL_DOUBLEWORD_BIT];
         state_reg.mapped <= CONTROL_RESET[CTL_MAPPED_BIT];
         state_reg.last_cause <= cause_none;
         state_reg.gpr_clear <= 1'b0;
         state_reg.vector_valid <= 1'b0;
         state_reg.vector_addr <= '0;
         state_reg.vector_cause <= cause_none;
         state_reg.blocked <= 1'b0;
         state_reg.prdata <= 32'h0;
      end else begin
         state_reg.reset_seen <= state_next.reset_seen;
         state_reg.status <= state_next.status;
         state_reg.doubleword <= state_next.doubleword;
         state_reg.mapped <= state_next.mapped;
         state_reg.last_cause <= state_next.last_cause;
         state_reg.gpr_clear <= state_next.gpr_clear;
         state_reg.vector_valid <= state_next.vector_valid;
         state_reg.vector_addr <= state_next.vector_addr;
         state_reg.vector_cause <= state_next.vector_cause;
         state_reg.blocked <= state_next.blocked;
         state_reg.prdata <= state_next.prdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign o_prdata = state_reg.prdata;
   assign o_status_word = state_reg.status;
   assign o_privileged = state_reg.status[PRIV_BIT];
   assign o_mem_protect_en = !state_reg.status[PRIV_BIT];
   assign o_doubleword_mode = state_reg.doubleword;
   assign o_gpr_clear = state_reg.gpr_clear;
   assign o_vector_valid = state_reg.vector_valid;
   assign o_vector_addr = state_reg.vector_addr;
   assign o_vector_cause = state_reg.vector_cause;
   assign o_instr_blocked = state_reg.blocked;
endmodule

// ### hdl/status_word_pkg.sv
// constants and types shared by the status word control logic
package status_word_pkg;
   // apb register byte offsets
   localparam logic [11:0] STATUS_WORD_OFF = 12'h000;
   localparam logic [11:0] CONTROL_OFF = 12'h004;
   localparam logic [11:0] TRAP_INFO_OFF = 12'h008;
   // single status word field positions
   localparam int PRIV_BIT = 0;
   localparam int CC_LO = 1;
   localparam int CC_HI = 4;
   localparam int EXT_BIT = 5;
   localparam int LAST_POS_BIT = 6;
   localparam int UNASSIGNED_LO = 7;
   localparam int UNASSIGNED_HI = 12;
   localparam int PC_LO = 13;
   localparam int PC_HI = 29;
   localparam int NEXT_POS_BIT = 30;
   // control register bits
   localparam int CTL_DOUBLEWORD_BIT = 0;
   localparam int CTL_MAPPED_BIT = 1;
   // writable bits of the status word: unassigned bits and bit 31 stay zero
   localparam logic [31:0] STATUS_WRITE_MASK = 32'h7fff_e07f;
   // value after reset: privileged, everything else zero
   localparam logic [31:0] STATUS_RESET = 32'h0000_0001;
   localparam logic [1:0] CONTROL_RESET = 2'h0;
   // address limits
   localparam int ADDR_W = 24;
   localparam int BASE_ADDR_W = 19;
   // vector table base in protected private memory
   localparam logic [23:0] VECTOR_BASE = 24'h000100;
   localparam logic [3:0] IO_CLASS_E = 4'he;
   localparam logic [3:0] IO_CLASS_MAX_LOW = 4'h3;

   typedef enum logic [3:0] {
      cause_none,
      cause_interrupt,
      cause_nonpresent,
      cause_undefined,
      cause_priv_violation,
      cause_protect_write,
      cause_mem_error,
      cause_arith,
      cause_monitor_call,
      cause_supervisor_call
   } cause_t;

   typedef enum logic [2:0] {
      kind_plain,
      kind_privileged,
      kind_io,
      kind_branch_link,
      kind_branch_reset_int,
      kind_load_doubleword,
      kind_monitor_call,
      kind_supervisor_call
   } instr_kind_t;
endpackage

// ### hdl/addr_mode_check.sv
// memory addressing mode limit check
`timescale 1ns/100ps
module addr_mode_check (
   input wire logic i_extended,
   input wire logic i_mapped,
   input wire logic i_doubleword,
   input wire logic i_fetch,
   input wire logic i_ext_space,
   input wire logic [status_word_pkg::ADDR_W-1:0] i_addr,
   output logic o_fault
);
   import status_word_pkg::*;

   logic above_base;

   always_comb begin
      above_base = |i_addr[ADDR_W-1:BASE_ADDR_W];
      o_fault = 1'b0;
      if (i_mapped) begin
         if (!i_doubleword) begin
            o_fault = 1'b1;
         end else if (i_fetch && i_ext_space) begin
            o_fault = 1'b1;
         end else if (!i_extended && i_ext_space) begin
            o_fault = 1'b1;
         end else begin
            o_fault = above_base;
         end
      end else if (i_extended) begin
         o_fault = i_fetch && above_base;
      end else begin
         o_fault = above_base || i_ext_space;
      end
   end
endmodule

// ### dv/status_word_ctrl_props.sv
// assertions on the status word control ports
`timescale 1ns/100ps
module status_word_ctrl_props (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_instr_valid,
   input wire status_word_pkg::instr_kind_t i_instr_kind,
   input wire logic i_cc_defined,
   input wire logic i_arith_exc,
   input wire logic [31:0] i_result,
   input wire logic [17:0] i_branch_ea,
   input wire logic i_indirect,
   input wire logic [31:0] i_indirect_word,
   input wire logic i_event_req,
   input wire status_word_pkg::cause_t i_event_cause,
   input wire logic [31:0] o_status_word,
   input wire logic o_privileged,
   input wire logic o_mem_protect_en,
   input wire logic o_gpr_clear,
   input wire logic o_vector_valid,
   input wire logic [status_word_pkg::ADDR_W-1:0] o_vector_addr,
   input wire status_word_pkg::cause_t o_vector_cause,
   input wire logic o_instr_blocked
);
   import status_word_pkg::*;
   logic [3:0] cc_exp;
   assign cc_exp = {i_result == 32'h0, i_result[31], !i_result[31] && i_result != 32'h0, i_arith_exc};
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_nrst);
   ////////////////////////////////////////
   sequence s_retire;
      i_instr_valid && !i_event_req;
   endsequence
   sequence s_gated;
      s_retire ##0 (!o_privileged && (i_instr_kind inside {kind_privileged, kind_io, kind_branch_reset_int,
         kind_load_doubleword}));
   endsequence
   a_unassigned_zero:
      assert property (o_status_word[12:7] == 6'h0 && !o_status_word[31]) else $error("unassigned bits set");
   a_protect_priv:
      assert property (o_privileged == o_status_word[0] && o_mem_protect_en == !o_status_word[0])
      else $error("privilege flag mismatch");
   a_cc_result:
      assert property (s_retire ##0 (i_instr_kind == kind_plain && i_cc_defined) |=> o_status_word[4:1] == $past(cc_exp))
      else $error("condition code wrong");
   a_branch_link:
      assert property (s_retire ##0 i_instr_kind == kind_branch_link |=> o_status_word[30:13] == $past(i_branch_ea)
         && (!$past(i_indirect) || o_status_word[4:1] == $past(i_indirect_word[4:1]))) else $error("branch link wrong");
   a_priv_refused:
      assert property (s_gated |=> o_instr_blocked && o_privileged && o_vector_cause == cause_priv_violation)
      else $error("privileged op not refused");
   a_event_vector:
      assert property (i_event_req |=> o_vector_valid && o_privileged && o_vector_cause == $past(i_event_cause)
         && o_vector_addr == VECTOR_BASE + {18'h0, $past(i_event_cause), 2'h0}) else $error("event vector wrong");
   a_priv_drop:
      assert property ($fell(o_privileged) |-> $past(i_instr_valid)
         && ($past(i_instr_kind) inside {kind_branch_reset_int, kind_load_doubleword})) else $error("privilege lost");
   a_gpr_clear:
      assert property ($rose(i_nrst) |-> ##[2:4] o_gpr_clear ##1 !o_gpr_clear) else $error("no register clear");
endmodule
bind status_word_ctrl status_word_ctrl_props u_props (.*);

// ### dv/test_status_word_privilege_control.sv
// self-checking bench for the status word control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module test_status_word_privilege_control;
   import status_word_pkg::*;
   logic i_clk_sys = '0, i_nrst = '0, i_psel = '0, i_penable = '0, i_pwrite = '0, i_instr_valid = '0;
   logic i_cc_defined = '0, i_arith_exc = '0, i_last_right = '0, i_indirect = '0, i_event_req = '0;
   logic i_acc_valid = '0, i_acc_fetch = '0, i_acc_ext_space = '0, o_pready, o_pslverr, o_privileged, o_mem_protect_en;
   logic o_doubleword_mode, o_gpr_clear, o_vector_valid, o_instr_blocked, o_addr_fault, err;
   logic [11:0] i_paddr = '0;
   logic [3:0] i_io_class = '0;
   logic [17:0] i_next_loc = '0, i_branch_ea = '0;
   logic [23:0] i_acc_addr = '0, o_vector_addr;
   logic [31:0] i_pwdata = '0, i_result = '0, i_indirect_word = '0, i_new_status = '0, i_event_status = '0;
   logic [31:0] o_prdata, o_status_word, rd;
   instr_kind_t i_instr_kind = kind_plain;
   cause_t i_event_cause = cause_none, o_vector_cause;
   int fail_count = 0, num_checks = 0;
   status_word_ctrl uut (.*);
   always #4 i_clk_sys = ~i_clk_sys;
   ////////////////////////////////////////
   task automatic give_verdict;
      if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk_sys);
      i_psel <= 1'h1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk_sys);
      i_penable <= 1'h1;
      for (n = 0; n < 20 && !(n > 0 && o_pready === 1'h1); n++) @(posedge i_clk_sys);
      if (o_pready !== 1'h1) fail_count++;
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'h0;
      i_penable <= 1'h0;
   endtask
   task automatic retire(input instr_kind_t k);
      i_instr_kind <= k;
      i_instr_valid <= 1'h1;
      @(posedge i_clk_sys);
      i_instr_valid <= 1'h0;
      @(negedge i_clk_sys);
   endtask
   task automatic probe(input logic f, input logic x, input logic [23:0] a, input logic e);
      @(posedge i_clk_sys);
      i_acc_valid <= 1'h1;
      i_acc_fetch <= f;
      i_acc_ext_space <= x;
      i_acc_addr <= a;
      @(negedge i_clk_sys);
      `CHK("addr fault", e, o_addr_fault)
   endtask
   ////////////////////////////////////////
   task automatic t_regs;
      apb(1'h0, STATUS_WORD_OFF, 32'h0);
      `CHK("status reset", 32'h1, rd)
      apb(1'h1, STATUS_WORD_OFF, 32'hffff_ffff);
      apb(1'h0, STATUS_WORD_OFF, 32'h0);
      `CHK("status rw", 32'h7fff_e07f, rd)
      apb(1'h1, STATUS_WORD_OFF, 32'h0);
      apb(1'h0, STATUS_WORD_OFF, 32'h0);
      `CHK("status keep", 32'h1, rd)
      apb(1'h1, TRAP_INFO_OFF, 32'hf);
      apb(1'h0, TRAP_INFO_OFF, 32'h0);
      `CHK("trap ro", 32'h0, rd)
      apb(1'h0, 12'h00c, 32'h0);
      `CHK("unmapped", 33'h1_0000_0000, {err, rd})
   endtask
   task automatic t_cc;
      logic [31:0] v [4] = '{32'h0, 32'h5, 32'hffff_fffd, 32'h8000_0000};
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clk_sys);
         i_result <= v[i];
         i_cc_defined <= 1'h1;
         i_arith_exc <= i[0];
         i_last_right <= i[1];
         i_next_loc <= 18'h2a5a5 + 18'(i);
         retire(kind_plain);
         `CHK("cc", {v[i] == 0, v[i][31], v[i] != 0 && !v[i][31], i[0]}, o_status_word[4:1])
         `CHK("pc", {i_next_loc, i[1]}, {o_status_word[30:13], o_status_word[6]})
      end
      @(posedge i_clk_sys);
      i_cc_defined <= 1'h0;
      retire(kind_plain);
      `CHK("cc kept", 4'h5, o_status_word[4:1])
   endtask
   task automatic t_branch;
      @(posedge i_clk_sys);
      i_branch_ea <= 18'h3_1234;
      retire(kind_branch_link);
      `CHK("link", 18'h3_1234, o_status_word[30:13])
      @(posedge i_clk_sys);
      i_branch_ea <= 18'h0_0abc;
      i_indirect <= 1'h1;
      i_indirect_word <= 32'hffff_fff4;
      retire(kind_branch_link);
      `CHK("indirect", {18'h0_0abc, 4'ha}, {o_status_word[30:13], o_status_word[4:1]})
      @(posedge i_clk_sys);
      i_indirect <= 1'h0;
   endtask
   task automatic t_priv;
      instr_kind_t ks [4] = '{kind_privileged, kind_io, kind_branch_reset_int, kind_load_doubleword};
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clk_sys);
         retire(kind_load_doubleword);
         `CHK("drop", 2'h2, {o_mem_protect_en, o_privileged})
         @(posedge i_clk_sys);
         retire(ks[i]);
         `CHK("refuse", {2'h3, VECTOR_BASE + 24'h10, cause_priv_violation}, {o_instr_blocked, o_privileged, o_vector_addr, o_vector_cause})
      end
      @(posedge i_clk_sys);
      retire(kind_privileged);
      `CHK("allowed", 1'h0, o_instr_blocked)
   endtask
   task automatic t_events;
      for (int c = 1; c < 10; c++) begin
         @(posedge i_clk_sys);
         retire(kind_load_doubleword);
         @(posedge i_clk_sys);
         i_event_status <= 32'h2000;
         i_event_cause <= cause_t'(c);
         i_event_req <= 1'h1;
         @(posedge i_clk_sys);
         i_event_req <= 1'h0;
         @(negedge i_clk_sys);
         `CHK("event", {VECTOR_BASE + 24'(c * 4), cause_t'(c), 2'h3, 32'h2001}, {o_vector_addr, o_vector_cause, o_vector_valid, o_privileged, o_status_word})
      end
      @(posedge i_clk_sys);
      retire(kind_monitor_call);
      `CHK("monitor call", {cause_monitor_call, 2'h3}, {o_vector_cause, o_vector_valid, o_privileged})
      @(posedge i_clk_sys);
      retire(kind_supervisor_call);
      `CHK("supervisor call", {cause_supervisor_call, 1'h1}, {o_vector_cause, o_vector_valid})
      apb(1'h0, TRAP_INFO_OFF, 32'h0);
      `CHK("last cause", 4'h9, rd[3:0])
   endtask
   task automatic t_io;
      for (int i = 0; i < 16; i++) begin
         @(posedge i_clk_sys);
         i_io_class <= i[3:0];
         retire(kind_io);
         `CHK("io class", i > 3 && i != 14, o_instr_blocked)
      end
      apb(1'h1, CONTROL_OFF, 32'h1);
      @(posedge i_clk_sys);
      i_io_class <= 4'h5;
      retire(kind_io);
      `CHK("io dw", 1'h0, o_instr_blocked)
   endtask
   task automatic t_addr;
      apb(1'h1, CONTROL_OFF, 32'h0);
      apb(1'h1, STATUS_WORD_OFF, 32'h1);
      probe(1'h0, 1'h0, 24'h07ffff, 1'h0);
      probe(1'h0, 1'h0, 24'h080000, 1'h1);
      apb(1'h1, STATUS_WORD_OFF, 32'h21);
      probe(1'h0, 1'h0, 24'hffffff, 1'h0);
      apb(1'h1, CONTROL_OFF, 32'h2);
      probe(1'h0, 1'h0, 24'h000100, 1'h1);
      apb(1'h1, CONTROL_OFF, 32'h3);
      probe(1'h1, 1'h1, 24'h001000, 1'h1);
      probe(1'h0, 1'h1, 24'h001000, 1'h0);
      apb(1'h1, STATUS_WORD_OFF, 32'h1);
      probe(1'h0, 1'h0, 24'h000100, 1'h0);
   endtask
   task automatic t_reset;
      int n;
      @(posedge i_clk_sys);
      retire(kind_load_doubleword);
      @(posedge i_clk_sys);
      i_nrst <= 1'h0;
      repeat (3) @(posedge i_clk_sys);
      i_nrst <= 1'h1;
      for (n = 0; n < 10 && o_gpr_clear !== 1'h1; n++) @(negedge i_clk_sys);
      `CHK("reset", 36'ha_0000_0001, {o_gpr_clear, o_mem_protect_en, o_privileged, o_doubleword_mode, o_status_word})
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20) @(posedge i_clk_sys);
      i_nrst <= 1'h1;
      repeat (3) @(posedge i_clk_sys);
      t_regs;
      t_cc;
      t_branch;
      t_priv;
      t_events;
      t_io;
      t_addr;
      t_reset;
      give_verdict;
   end
   initial begin
      repeat (5000) @(posedge i_clk_sys);
      fail_count++;
      give_verdict;
   end
endmodule
